/* File: logic/asmu_mult.sv */
// Purpose: unsigned magnitude multiplier, dedicated-block or bit-serial
// Assumes: start is a one-cycle pulse; operands stable while serial run lasts
// Notes: done pulses one cycle; product valid while done is high
`timescale 1ns/1ps
module asmu_mult #(
  parameter int DW = 32,
  parameter bit use_dsp = 1'h0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // operands
  input wire logic start,
  input wire logic [DW-1:0] a_mag,
  input wire logic [DW-1:0] b_mag,
  // product
  output logic done,
  output logic [2*DW-1:0] prod
);
  import asmu_pkg::*;

  localparam int CW = $clog2(DW);

  if (DW < 2)
  begin : g_bad_dw
    $error("asmu_mult: width must be at least two");
  end

  logic done_q;
  logic [2*DW-1:0] prod_q;

  assign done = done_q;
  assign prod = prod_q;

  // ----------------------------------------------------------------
  // dedicated multiplier block
  // ----------------------------------------------------------------
  if (use_dsp)
  begin : g_dsp
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        done_q <= 1'h0;
        prod_q <= '0;
      end
      else
      begin
        done_q <= start;
        if (start)
          prod_q <= {{DW{1'h0}}, a_mag} * {{DW{1'h0}}, b_mag};
      end
    end
  end
  // ----------------------------------------------------------------
  // shift-add, one multiplier bit per cycle
  // ----------------------------------------------------------------
  else
  begin : g_serial
    logic [CW-1:0] cnt_q;
    logic run_q;
    logic [DW-1:0] mcand_q;
    logic [DW:0] sum;

    assign sum = {1'h0, prod_q[2*DW-1:DW]} + {1'h0, mcand_q};

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        done_q <= 1'h0;
        prod_q <= '0;
        cnt_q <= '0;
        run_q <= 1'h0;
        mcand_q <= '0;
      end
      else
      begin
        done_q <= 1'h0;
        if (start)
        begin
          prod_q <= {{DW{1'h0}}, b_mag};
          mcand_q <= a_mag;
          cnt_q <= '0;
          run_q <= 1'h1;
        end
        else if (run_q)
        begin
          if (prod_q[0])
            prod_q <= {sum, prod_q[DW-1:1]};
          else
            prod_q <= {1'h0, prod_q[2*DW-1:1]};
          cnt_q <= cnt_q + 1'h1;
          if (cnt_q == CW'(DW-1))
          begin
            run_q <= 1'h0;
            done_q <= 1'h1;
          end
        end
      end
    end
  end

endmodule

/* File: logic/asmu_unit.sv */
// Purpose: shift, multiply and divide datapath of the core's ALU, with an APB status port
// Assumes: pipeline inputs come from logic on pclk; one operation in flight at a time
// Notes: option parameters fix the structure at build time; CTRL can still gate rotates
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "asmu_defines.svh"
module asmu_unit #(
  parameter int DW = 32,
  parameter bit barrel_shift_select = 1'h0,
  parameter bit dsp_multiplier_select = 1'h0,
  parameter bit mul_div_ext_enable = 1'h0,
  parameter bit mul_only_ext_enable = 1'h0,
  parameter bit bitmanip_ext_enable = 1'h0,
  parameter bit float_in_int_regs_ext_enable = 1'h0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ASMU_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pipeline request
  input wire logic op_start,
  input asmu_pkg::asmu_op_e op_code,
  input wire logic [DW-1:0] op_a,
  input wire logic [DW-1:0] op_b,
  // pipeline answer
  output logic op_busy,
  output logic op_done,
  output logic op_illegal,
  output logic [DW-1:0] op_result
);
  import asmu_pkg::*;

  localparam int SW = $clog2(DW);
  // the multiplier exists only with one of the two multiply extensions
  localparam bit mul_en = mul_div_ext_enable | mul_only_ext_enable;
  localparam bit use_dsp = mul_en & dsp_multiplier_select;

  if (DW != 32)
  begin : g_bad_dw
    $error("asmu_unit: only a 32-bit datapath is supported");
  end
  if (mul_div_ext_enable && mul_only_ext_enable)
  begin : g_bad_ext
    $error("asmu_unit: full and multiply-only extensions are exclusive");
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_shift(asmu_op_e op);
    is_shift = (op == ASMU_OP_SLL) || (op == ASMU_OP_SRL) || (op == ASMU_OP_SRA) ||
               (op == ASMU_OP_ROL) || (op == ASMU_OP_ROR);
  endfunction

  function automatic logic is_rot(asmu_op_e op);
    is_rot = (op == ASMU_OP_ROL) || (op == ASMU_OP_ROR);
  endfunction

  function automatic logic is_mul(asmu_op_e op);
    is_mul = (op == ASMU_OP_MUL) || (op == ASMU_OP_MULH) || (op == ASMU_OP_MULHSU) ||
             (op == ASMU_OP_MULHU);
  endfunction

  function automatic logic is_div(asmu_op_e op);
    is_div = (op == ASMU_OP_DIV) || (op == ASMU_OP_DIVU) || (op == ASMU_OP_REM) ||
             (op == ASMU_OP_REMU);
  endfunction

  function automatic logic legal(asmu_op_e op, logic bm_allow);
    if (is_rot(op))
      legal = bitmanip_ext_enable & bm_allow;
    else if (is_shift(op))
      legal = 1'h1;
    else if (is_mul(op))
      legal = mul_en;
    else if (is_div(op))
      legal = mul_div_ext_enable;
    else if (op == ASMU_OP_FMANT)
      legal = float_in_int_regs_ext_enable;
    else
      legal = 1'h0;
  endfunction

  function automatic logic [DW-1:0] barrel(asmu_op_e op, logic [DW-1:0] a, logic [SW-1:0] amt);
    logic [2*DW-1:0] rl;
    logic [2*DW-1:0] rr;
    rl = {a, a} << amt;
    rr = {a, a} >> amt;
    case (op)
      ASMU_OP_SLL: barrel = a << amt;
      ASMU_OP_SRL: barrel = a >> amt;
      ASMU_OP_SRA: barrel = DW'($signed(a) >>> amt);
      ASMU_OP_ROL: barrel = rl[2*DW-1:DW];
      ASMU_OP_ROR: barrel = rr[DW-1:0];
      default: barrel = '0;
    endcase
  endfunction

  function automatic logic [DW-1:0] step(asmu_op_e op, logic [DW-1:0] a);
    case (op)
      ASMU_OP_SLL: step = {a[DW-2:0], 1'h0};
      ASMU_OP_SRL: step = {1'h0, a[DW-1:1]};
      ASMU_OP_SRA: step = {a[DW-1], a[DW-1:1]};
      ASMU_OP_ROL: step = {a[DW-2:0], a[DW-1]};
      ASMU_OP_ROR: step = {a[0], a[DW-1:1]};
      default: step = a;
    endcase
  endfunction

  function automatic logic [DW-1:0] negate(logic [DW-1:0] x, logic s);
    negate = s ? (~x + 1'h1) : x;
  endfunction

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  asmu_state_e st_q;
  asmu_op_e opr_q;
  logic busy_q, done_q, ill_q;
  logic [DW-1:0] res_q, sh_q, quo_q, rem_q, den_q;
  logic [SW:0] cnt_q;
  logic neg_q, rneg_q;
  logic ctrl_bm_q;
  logic acc, ok, sa, sb;
  logic [SW-1:0] amt;
  logic [DW-1:0] mag_a, mag_b;
  logic mul_done;
  logic [2*DW-1:0] mul_prod, mul_fix;
  logic [2*`ASMU_FMANT_W-1:0] fm_prod;
  logic [DW-1:0] fm_res;
  logic [DW:0] trial;
  logic [DW-1:0] nq, nr;

  assign acc = op_start && (st_q == ASMU_ST_IDLE);
  assign ok = legal(op_code, ctrl_bm_q);
  assign amt = op_b[SW-1:0];
  assign sa = op_a[DW-1] && (op_code == ASMU_OP_MUL || op_code == ASMU_OP_MULH ||
                             op_code == ASMU_OP_MULHSU || op_code == ASMU_OP_DIV || op_code == ASMU_OP_REM);
  assign sb = op_b[DW-1] && (op_code == ASMU_OP_MUL || op_code == ASMU_OP_MULH ||
                             op_code == ASMU_OP_DIV || op_code == ASMU_OP_REM);
  assign mag_a = negate(op_a, sa);
  assign mag_b = negate(op_b, sb);
  // float mantissas always go to the dedicated multiplier, whatever the integer choice
  assign fm_prod = op_a[`ASMU_FMANT_W-1:0] * op_b[`ASMU_FMANT_W-1:0];
  assign fm_res = fm_prod[`ASMU_FMANT_SEL_LSB +: DW];

  // ----------------------------------------------------------------
  // multiplier
  // ----------------------------------------------------------------
  if (mul_en)
  begin : g_mul
    asmu_mult #(
      .DW(DW),
      .use_dsp(use_dsp)
    ) u_mult (
      .pclk(pclk),
      .presetn(presetn),
      .start(acc && ok && is_mul(op_code)),
      .a_mag(mag_a),
      .b_mag(mag_b),
      .done(mul_done),
      .prod(mul_prod)
    );
  end
  else
  begin : g_no_mul
    assign mul_done = 1'h0;
    assign mul_prod = '0;
  end

  assign mul_fix = neg_q ? (~mul_prod + 1'h1) : mul_prod;

  // restoring division step; a zero divisor yields all ones and the dividend
  assign trial = {rem_q, quo_q[DW-1]} - {1'h0, den_q};
  assign nr = trial[DW] ? {rem_q[DW-2:0], quo_q[DW-1]} : trial[DW-1:0];
  assign nq = {quo_q[DW-2:0], ~trial[DW]};

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ASMU_ST_IDLE;
      busy_q <= 1'h0;
      done_q <= 1'h0;
      ill_q <= 1'h0;
      res_q <= '0;
      opr_q <= ASMU_OP_SLL;
      sh_q <= '0;
      cnt_q <= '0;
      quo_q <= '0;
      rem_q <= '0;
      den_q <= '0;
      neg_q <= 1'h0;
      rneg_q <= 1'h0;
    end
    else
    begin
      done_q <= 1'h0;
      case (st_q)
        ASMU_ST_IDLE:
          if (op_start)
          begin
            opr_q <= op_code;
            ill_q <= ~ok;
            if (!ok)
            begin
              res_q <= '0;
              done_q <= 1'h1;
            end
            else if (is_shift(op_code) && barrel_shift_select)
            begin
              res_q <= barrel(op_code, op_a, amt);
              done_q <= 1'h1;
            end
            else if (is_shift(op_code) && amt == '0)
            begin
              res_q <= op_a;
              done_q <= 1'h1;
            end
            else if (is_shift(op_code))
            begin
              sh_q <= op_a;
              cnt_q <= {1'h0, amt};
              st_q <= ASMU_ST_SHIFT;
              busy_q <= 1'h1;
            end
            else if (is_mul(op_code))
            begin
              neg_q <= sa ^ sb;
              st_q <= ASMU_ST_MUL;
              busy_q <= 1'h1;
            end
            else if (is_div(op_code))
            begin
              quo_q <= mag_a;
              rem_q <= '0;
              den_q <= mag_b;
              neg_q <= (sa ^ sb) && (op_b != '0);
              rneg_q <= sa;
              cnt_q <= (SW+1)'(DW);
              st_q <= ASMU_ST_DIV;
              busy_q <= 1'h1;
            end
            else
            begin
              res_q <= fm_res;
              done_q <= 1'h1;
            end
          end
        ASMU_ST_SHIFT:
        begin
          sh_q <= step(opr_q, sh_q);
          cnt_q <= cnt_q - 1'h1;
          if (cnt_q == (SW+1)'(1))
          begin
            res_q <= step(opr_q, sh_q);
            done_q <= 1'h1;
            busy_q <= 1'h0;
            st_q <= ASMU_ST_IDLE;
          end
        end
        ASMU_ST_MUL:
          if (mul_done)
          begin
            res_q <= (opr_q == ASMU_OP_MUL) ? mul_fix[DW-1:0] : mul_fix[2*DW-1:DW];
            done_q <= 1'h1;
            busy_q <= 1'h0;
            st_q <= ASMU_ST_IDLE;
          end
        ASMU_ST_DIV:
        begin
          quo_q <= nq;
          rem_q <= nr;
          cnt_q <= cnt_q - 1'h1;
          if (cnt_q == (SW+1)'(1))
          begin
            res_q <= (opr_q == ASMU_OP_DIV || opr_q == ASMU_OP_DIVU) ? negate(nq, neg_q) : negate(nr, rneg_q);
            done_q <= 1'h1;
            busy_q <= 1'h0;
            st_q <= ASMU_ST_IDLE;
          end
        end
        default:
        begin
          st_q <= ASMU_ST_IDLE;
          busy_q <= 1'h0;
        end
      endcase
    end
  end

  assign op_busy = busy_q;
  assign op_done = done_q;
  assign op_illegal = ill_q;
  assign op_result = res_q;

  // ----------------------------------------------------------------
  // statistics
  // ----------------------------------------------------------------
  logic [`ASMU_CYC_W-1:0] cyc_q, last_cyc_q;
  logic [31:0] op_cnt_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_q <= '0;
      last_cyc_q <= '0;
      op_cnt_q <= '0;
    end
    else
    begin
      // saturates so a long divide never wraps to a short figure
      if (acc)
        cyc_q <= `ASMU_CYC_W'(1);
      else if (busy_q && cyc_q != '1)
        cyc_q <= cyc_q + 1'h1;
      if (done_q)
      begin
        last_cyc_q <= cyc_q;
        op_cnt_q <= op_cnt_q + 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic setup, wr_ctrl;

  assign setup = psel && !penable;
  assign wr_ctrl = psel && penable && pready_q && pwrite && (paddr == `ASMU_OFS_CTRL);

  function automatic logic [31:0] reg_read(logic [`ASMU_ADDR_W-1:0] a);
    reg_read = '0;
    case (a)
      `ASMU_OFS_CTRL: reg_read[`ASMU_CTRL_BM_ALLOW] = ctrl_bm_q;
      `ASMU_OFS_STATUS:
      begin
        reg_read[`ASMU_STAT_BUSY] = busy_q;
        reg_read[`ASMU_STAT_ILLEGAL] = ill_q;
        reg_read[`ASMU_STAT_CYC_LSB +: `ASMU_CYC_W] = last_cyc_q;
      end
      `ASMU_OFS_COUNT: reg_read = op_cnt_q;
      default: reg_read = '0;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q <= pwrite ? 32'h0 : reg_read(paddr);
        // writes to read-only words and any unmapped word are refused
        pslverr_q <= !((paddr == `ASMU_OFS_CTRL) ||
                       (!pwrite && (paddr == `ASMU_OFS_STATUS || paddr == `ASMU_OFS_COUNT)));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_bm_q <= `ASMU_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_bm_q <= pwdata[`ASMU_CTRL_BM_ALLOW];
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_accept(cond);
    op_start && (st_q == ASMU_ST_IDLE) && cond;
  endsequence

  a_fast_shift_done:
    assert property (s_accept(barrel_shift_select && is_shift(op_code) && ok) |=>
                     op_done && !op_illegal && op_result == barrel($past(op_code), $past(op_a), $past(amt)))
    else $error("barrel shift result or timing wrong");
  a_serial_shift_long:
    assert property (s_accept(!barrel_shift_select && is_shift(op_code) && ok && amt == 5'h1F) |->
                     ##1 (!op_done)[*8] ##24 op_done)
    else $error("serial shift of 31 not done at cycle 32");
  a_serial_shift_zero:
    assert property (s_accept(!barrel_shift_select && is_shift(op_code) && ok && amt == 5'h00) |=>
                     op_done && op_result == $past(op_a))
    else $error("zero serial shift wrong");
  a_mul_dsp_time:
    assert property (s_accept(use_dsp && is_mul(op_code) && ok) |-> ##2 op_done)
    else $error("dedicated multiply not done in two cycles");
  a_mul_serial_time:
    assert property (s_accept(mul_en && !use_dsp && is_mul(op_code) && ok) |-> ##1 op_busy[*8] ##26 op_done)
    else $error("serial multiply timing wrong");
  a_mul_absent:
    assert property (s_accept(!mul_en && is_mul(op_code)) |=> op_done && op_illegal)
    else $error("multiply accepted without multiply extension");
  a_div_time:
    assert property (s_accept(mul_div_ext_enable && is_div(op_code)) |-> ##33 (op_done && !op_illegal))
    else $error("divide not done at cycle 33");
  a_bm_gated:
    assert property (s_accept(is_rot(op_code) && !(bitmanip_ext_enable && ctrl_bm_q)) |=> op_done && op_illegal)
    else $error("rotate executed while not available");
  a_fmant_result:
    assert property (s_accept(float_in_int_regs_ext_enable && op_code == ASMU_OP_FMANT) |=>
                     op_done && op_result == $past(fm_res))
    else $error("mantissa product wrong");
  a_done_pulse:
    assert property (op_done && !acc |=> !op_done)
    else $error("done held longer than one cycle");
  a_busy_ends_done:
    assert property ($fell(op_busy) |-> op_done)
    else $error("busy fell without done");

endmodule

/* File: pkg/asmu_defines.svh */
// Purpose: named offsets, fields, reset values and sizes of the shift/multiply unit
// Assumes: included by bare name from the design files
// Notes: the package holds the types
`ifndef ASMU_DEFINES_SVH
`define ASMU_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ASMU_ADDR_W 12
`define ASMU_OFS_CTRL 12'h000
`define ASMU_OFS_STATUS 12'h004
`define ASMU_OFS_COUNT 12'h008

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define ASMU_CTRL_RESET 1'h1
`define ASMU_CTRL_BM_ALLOW 0
`define ASMU_STAT_BUSY 0
`define ASMU_STAT_ILLEGAL 1
`define ASMU_STAT_CYC_LSB 8
`define ASMU_CYC_W 8

// ----------------------------------------------------------------
// float mantissa product
// ----------------------------------------------------------------
`define ASMU_FMANT_W 24
`define ASMU_FMANT_SEL_LSB 16

`endif

/* File: pkg/asmu_pkg.sv */
// Purpose: types shared by the shift/multiply unit
// Assumes: nothing
// Notes: operation codes are issued by the execute pipeline
package asmu_pkg;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ASMU_OP_SLL = 4'h0,
    ASMU_OP_SRL = 4'h1,
    ASMU_OP_SRA = 4'h2,
    ASMU_OP_ROL = 4'h3,
    ASMU_OP_ROR = 4'h4,
    ASMU_OP_MUL = 4'h5,
    ASMU_OP_MULH = 4'h6,
    ASMU_OP_MULHSU = 4'h7,
    ASMU_OP_MULHU = 4'h8,
    ASMU_OP_DIV = 4'h9,
    ASMU_OP_DIVU = 4'hA,
    ASMU_OP_REM = 4'hB,
    ASMU_OP_REMU = 4'hC,
    ASMU_OP_FMANT = 4'hD
  } asmu_op_e;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASMU_ST_IDLE = 2'h0,
    ASMU_ST_SHIFT = 2'h1,
    ASMU_ST_MUL = 2'h3,
    ASMU_ST_DIV = 2'h2
  } asmu_state_e;

endpackage

/* File: verif/asmu_pipe_model.sv */
// Purpose: execute pipeline stand-in that issues one operation and waits for done
// Assumes: one operation in flight; requests change only after a rising edge
// Notes: operands are inverted once done is seen, so a late read of them shows up
`timescale 1ns/1ps
module asmu_pipe_model (
  // clock
  input wire logic pclk,
  // request to the unit
  output logic op_start,
  output asmu_pkg::asmu_op_e op_code,
  output logic [31:0] op_a,
  output logic [31:0] op_b,
  // answer from the unit
  input wire logic op_done
);
  import asmu_pkg::*;

  initial
  begin
    op_start = 1'h0;
    op_code = ASMU_OP_SLL;
    op_a = 32'h0;
    op_b = 32'h0;
  end

  // ----------------------------------------------------------------
  // issue: lat counts edges from accept to done, -1 on timeout
  // ----------------------------------------------------------------
  task automatic issue(input asmu_op_e c, input logic [31:0] a, input logic [31:0] b, output int lat);
    int n;
    @(posedge pclk);
    op_start <= 1'h1;
    op_code <= c;
    op_a <= a;
    op_b <= b;
    @(posedge pclk);
    op_start <= 1'h0;
    lat = -1;
    n = 0;
    while (lat < 0 && n < 100)
    begin
      @(posedge pclk);
      n++;
      if (op_done === 1'h1)
        lat = n;
    end
    // operands held until done, released only afterwards
    op_a <= ~a;
    op_b <= ~b;
  endtask
endmodule

/* File: verif/asmu_unit_tb.sv */
// Purpose: self-checking bench, serial and fast builds side by side
// Assumes: both builds see the same operations and register traffic
// Notes: expected values are worked out by hand from the operands
`timescale 1ns/1ps
module asmu_unit_tb;
  import asmu_pkg::*;

  // both builds carry the same extensions so they answer the same operations
  localparam bit ext_on = 1'h1;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, f_pready, f_pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, f_prdata;
  logic op_start, op_busy, op_done, op_illegal, f_done, f_illegal, f_busy;
  asmu_op_e op_code;
  logic [31:0] op_a, op_b, op_result, f_result;
  int miscompares, checks, fcnt, flat, nops;

  asmu_unit #(.mul_div_ext_enable(ext_on), .bitmanip_ext_enable(ext_on), .float_in_int_regs_ext_enable(ext_on))
  i_asmu_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_start(op_start), .op_code(op_code), .op_a(op_a), .op_b(op_b), .op_busy(op_busy),
    .op_done(op_done), .op_illegal(op_illegal), .op_result(op_result));
  // fast build: barrel shifter and dedicated multiplier, checked on every output
  asmu_unit #(.barrel_shift_select(1'h1), .dsp_multiplier_select(1'h1), .mul_div_ext_enable(ext_on),
    .bitmanip_ext_enable(ext_on), .float_in_int_regs_ext_enable(ext_on))
  i_asmu_unit_fast (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(f_prdata), .pready(f_pready), .pslverr(f_pslverr),
    .op_start(op_start), .op_code(op_code), .op_a(op_a), .op_b(op_b), .op_busy(f_busy),
    .op_done(f_done), .op_illegal(f_illegal), .op_result(f_result));
  asmu_pipe_model i_asmu_pipe_model (.pclk(pclk), .op_start(op_start), .op_code(op_code),
    .op_a(op_a), .op_b(op_b), .op_done(op_done));

  initial
  begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  // edges from accept to done of the fast build
  always @(posedge pclk)
  begin
    fcnt <= op_start ? 1 : fcnt + 1;
    if (f_done === 1'h1)
      flat <= fcnt;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, input logic [31:0] erd,
    input logic eer);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
    begin
      miscompares++;
      final_report();
    end
    chk("fast_pready", 32'h1, {31'h0, f_pready});
    if (!w)
    begin
      chk("prdata", erd, prdata);
      chk("fast_prdata", erd, f_prdata);
    end
    chk("pslverr", {31'h0, eer}, {31'h0, pslverr});
    chk("fast_pslverr", {31'h0, eer}, {31'h0, f_pslverr});
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic run(input asmu_op_e c, input logic [31:0] a, b, r, input int l, fl, input logic il);
    int lat;
    i_asmu_pipe_model.issue(c, a, b, lat);
    @(negedge pclk);
    nops++;
    if (lat < 0)
    begin
      miscompares++;
      final_report();
    end
    chk("slow_lat", l, lat);
    chk("fast_lat", fl, flat);
    chk("slow_res", r, op_result);
    chk("fast_res", r, f_result);
    chk("illegal", {30'h0, il, il}, {30'h0, op_illegal, f_illegal});
    chk("busy", 32'h0, {30'h0, op_busy, f_busy});
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    run(ASMU_OP_SLL, 32'h80000001, 32'h2, 32'h4, 3, 1, 1'h0);
    run(ASMU_OP_SRA, 32'h80000000, 32'h1F, 32'hFFFFFFFF, 32, 1, 1'h0);
    run(ASMU_OP_SRL, 32'hF0, 32'h0, 32'hF0, 1, 1, 1'h0);
    run(ASMU_OP_ROR, 32'h1, 32'h4, 32'h10000000, 5, 1, 1'h0);
    run(ASMU_OP_ROL, 32'h80000000, 32'h4, 32'h8, 5, 1, 1'h0);
    run(ASMU_OP_MUL, 32'h10000, 32'h30003, 32'h30000, 34, 2, 1'h0);
    run(ASMU_OP_MULHU, 32'h10000, 32'h30003, 32'h3, 34, 2, 1'h0);
    run(ASMU_OP_MULH, 32'hFFFFFFFF, 32'h2, 32'hFFFFFFFF, 34, 2, 1'h0);
    run(ASMU_OP_MULHSU, 32'h2, 32'h80000000, 32'h1, 34, 2, 1'h0);
    run(ASMU_OP_DIV, 32'h80000000, 32'hFFFFFFFF, 32'h80000000, 33, 33, 1'h0);
    run(ASMU_OP_DIV, 32'h5, 32'h0, 32'hFFFFFFFF, 33, 33, 1'h0);
    run(ASMU_OP_DIVU, 32'h64, 32'h7, 32'hE, 33, 33, 1'h0);
    run(ASMU_OP_REM, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFF, 33, 33, 1'h0);
    run(ASMU_OP_REMU, 32'h5, 32'h0, 32'h5, 33, 33, 1'h0);
    run(ASMU_OP_FMANT, 32'h800000, 32'h800000, 32'h40000000, 1, 1, 1'h0);
    apb(1'h1, 12'h000, 32'h0, 32'h0, 1'h0);
    run(ASMU_OP_ROL, 32'h3, 32'h1, 32'h0, 1, 1, 1'h1);
    apb(1'h0, 12'h004, 32'h0, 32'h102, 1'h0);
    apb(1'h0, 12'h00C, 32'h0, 32'h0, 1'h1);
    apb(1'h1, 12'h004, 32'h0, 32'h0, 1'h1);
    apb(1'h0, 12'h000, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 12'h008, 32'h0, nops, 1'h0);
    apb(1'h1, 12'h000, 32'h1, 32'h0, 1'h0);
    run(ASMU_OP_ROL, 32'h3, 32'h1, 32'h6, 2, 1, 1'h0);
    final_report();
  end
endmodule
